/* File: hw/scm_port_map.sv */
// Per-port configuration space decoder with capability chains and groups.
`timescale 1ns/10ps
`default_nettype none
module scm_port_map
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire scm_pkg::scm_cfg_t cfg,
    input wire scm_pkg::scm_req_t req,
    output scm_pkg::scm_rsp_t rsp,
    output logic stn_present,
    output logic chip_present,
    output logic vsw_present
);
    import scm_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        scm_rsp_t rsp;
        logic stn;
        logic chip;
        logic vsw;
        logic [SCM_STORE_WORDS-1:0][31:0] store;
    } scm_state_t;

    scm_state_t st_r;
    scm_state_t st_nxt;
    logic rom_hit;
    logic [31:0] rom_data;
    logic mcast_on;
    logic acs_on;
    logic pwrb_on;
    logic stn_port;
    logic chip_port;
    logic legacy;
    logic vmode;
    logic side_ok;
    logic grp_ok;
    logic in_stn;
    logic in_chip;
    logic in_vsw;
    logic in_store;
    logic dev_hit;
    logic [3:0] slot;

    // Inclusive range test used by every group decode.
    function automatic logic in_rng(input logic [11:0] a,
                                    input logic [11:0] lo,
                                    input logic [11:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // Byte lane merge for writes into the scratch store.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[8*i +: 8] = wd[8*i +: 8];
        end
        merge = r;
    endfunction

    // ****************************************************************
    // Presence decode.
    // ****************************************************************
    // Mode, port number, upstream and access control enable decide which blocks exist in this port.
    always_comb
    begin
        legacy = (cfg.mode == SCM_MODE_LEGACY);
        vmode = (cfg.mode == SCM_MODE_VSW);
        mcast_on = !legacy;
        acs_on = cfg.acs_en;
        pwrb_on = cfg.upstream;
        chip_port = (cfg.port_num == SCM_PORT_CHIP);
        stn_port = chip_port || (cfg.port_num == SCM_PORT_ST4)
                   || (cfg.port_num == SCM_PORT_ST5);
        side_ok = !vmode || (req.src == SCM_SRC_MGMT)
                  || (req.src == SCM_SRC_SIDE);
        grp_ok = side_ok && (!legacy || req.virt_side);
    end

    scm_rom scm_rom_i
    (
        .addr(req.addr),
        .mcast_on(mcast_on),
        .acs_on(acs_on),
        .pwrb_on(pwrb_on),
        .hit(rom_hit),
        .data(rom_data)
    );

    // Group decode of the request address.
    always_comb
    begin
        in_stn = stn_port && grp_ok
                 && in_rng(req.addr, SCM_STN_LO, SCM_STN_HI);
        in_chip = chip_port && grp_ok
                  && in_rng(req.addr, SCM_CHIP_LO, SCM_CHIP_HI);
        in_vsw = chip_port && vmode && side_ok
                 && (in_rng(req.addr, SCM_VSW_LO, SCM_VSW_HI)
                     || req.addr == SCM_VSW2);
        in_store = in_stn || in_chip || in_vsw;
        dev_hit = in_store;
        slot = req.addr[5:2];
    end

    // ****************************************************************
    // Next state.
    // ****************************************************************
    // Config and memory sources follow one path; misses read zero.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rsp.valid = req.valid;
        st_nxt.rsp.hit = 1'b0;
        st_nxt.rsp.rdata = SCM_ZERO;
        // Presence follows the port setup only; idle request lines carry
        // no meaning, so the interface side is enforced per access instead.
        st_nxt.stn = stn_port;
        st_nxt.chip = chip_port;
        st_nxt.vsw = chip_port && vmode;
        if (req.valid)
        begin
            if (rom_hit)
            begin
                st_nxt.rsp.hit = 1'b1;
                st_nxt.rsp.rdata = req.write ? SCM_ZERO : rom_data;
            end
            else if (dev_hit)
            begin
                st_nxt.rsp.hit = 1'b1;
                if (req.write)
                    st_nxt.store[slot] = merge(st_r.store[slot],
                                               req.wdata, req.be);
                else
                    st_nxt.rsp.rdata = st_r.store[slot];
            end
            // Anything else is reserved: zero read, write dropped.
        end
    end

    // Register the whole state.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign rsp = st_r.rsp;
    assign stn_present = st_r.stn;
    assign chip_present = st_r.chip;
    assign vsw_present = st_r.vsw;

endmodule // scm_port_map
`default_nettype wire

/* File: hw/scm_pkg.sv */
// Package of constants and carrier types for the per-port config-space map.
// Overview of operation
// - Capability pointer is 40h; power management: ID 01h, next 48h.
// - Interrupt message capability at 48h returns ID 05h, next 68h.
// - Express capability at 68h returns ID 10h, next A4h.
// - Subsystem identity at A4h returns ID 0Dh, next 00h, ending chain.
// - Serial number at 100h returns ID 0003h, version 1h, next FB4h.
// - Error reporting at FB4h returns ID 0001h, next 138h.
// - Power budget at 138h returns ID 0004h, next 148h, upstream only.
// - Virtual channel at 148h: ID 0002h; next E00h with multicast else 000h.
// - Multicast at E00h: ID 0012h; next F24h with access control else B70h.
// - Access control decodes at F24h only, returns 000Dh, next B70h.
// - Vendor capability at B70h: ID 000Bh, next 000h, ending extended chain.
// - Multicast block exists except in legacy isolating port mode.
// - Vswitch mode: chip, station groups only for management, sideband.
// - Legacy isolating port shows chip, station groups virtual-side only.
// - Ports 0, 16, 20 have station groups; port 0 adds chip, virtual switch.
// - Virtual switch group 900h to 9ECh and F20h: port 0 in that mode only.
// - Configuration and memory requests both reach the same registers.
package scm_pkg;

    // ****************************************************************
    // Address and identity constants.
    // ****************************************************************
    localparam int SCM_AW = 12;
    localparam logic [4:0] SCM_PORT_CHIP = 5'h00;
    localparam logic [4:0] SCM_PORT_ST4 = 5'h10;
    localparam logic [4:0] SCM_PORT_ST5 = 5'h14;

    localparam logic [11:0] SCM_OFF_CAPPTR = 12'h034;
    localparam logic [11:0] SCM_OFF_PM = 12'h040;
    localparam logic [11:0] SCM_OFF_MSI = 12'h048;
    localparam logic [11:0] SCM_OFF_EXP = 12'h068;
    localparam logic [11:0] SCM_OFF_SSID = 12'h0a4;
    localparam logic [11:0] SCM_OFF_DSN = 12'h100;
    localparam logic [11:0] SCM_OFF_PWRB = 12'h138;
    localparam logic [11:0] SCM_OFF_VC = 12'h148;
    localparam logic [11:0] SCM_OFF_VEND = 12'hb70;
    localparam logic [11:0] SCM_OFF_MCAST = 12'he00;
    localparam logic [11:0] SCM_OFF_ACS = 12'hf24;
    localparam logic [11:0] SCM_OFF_AER = 12'hfb4;
    localparam logic [11:0] SCM_OFF_NONE = 12'h000;

    localparam logic [7:0] SCM_ID_PM = 8'h01;
    localparam logic [7:0] SCM_ID_MSI = 8'h05;
    localparam logic [7:0] SCM_ID_EXP = 8'h10;
    localparam logic [7:0] SCM_ID_SSID = 8'h0d;
    localparam logic [15:0] SCM_XID_DSN = 16'h0003;
    localparam logic [15:0] SCM_XID_AER = 16'h0001;
    localparam logic [15:0] SCM_XID_PWRB = 16'h0004;
    localparam logic [15:0] SCM_XID_VC = 16'h0002;
    localparam logic [15:0] SCM_XID_MCAST = 16'h0012;
    localparam logic [15:0] SCM_XID_ACS = 16'h000d;
    localparam logic [15:0] SCM_XID_VEND = 16'h000b;
    localparam logic [3:0] SCM_XVER = 4'h1;

    // Device-specific group ranges, inclusive word addresses.
    localparam logic [11:0] SCM_STN_LO = 12'h200;
    localparam logic [11:0] SCM_STN_HI = 12'h25c;
    localparam logic [11:0] SCM_CHIP_LO = 12'h260;
    localparam logic [11:0] SCM_CHIP_HI = 12'h3ac;
    localparam logic [11:0] SCM_VSW_LO = 12'h900;
    localparam logic [11:0] SCM_VSW_HI = 12'h9ec;
    localparam logic [11:0] SCM_VSW2 = 12'hf20;
    localparam logic [11:0] SCM_MC_HI = 12'he2c;
    localparam logic [11:0] SCM_ACS_HI = 12'hf2c;
    localparam logic [11:0] SCM_PWRB_HI = 12'h144;
    localparam logic [11:0] SCM_STORE_LO = 12'h1c0;

    // Scratch store for device-specific words; depth of word slots.
    localparam int SCM_STORE_WORDS = 16;
    localparam logic [31:0] SCM_ZERO = 32'h0000_0000;

    // ****************************************************************
    // Modes and carriers.
    // ****************************************************************
    typedef enum logic [1:0] {
        SCM_MODE_BASE = 2'b00,
        SCM_MODE_VSW = 2'b01,
        SCM_MODE_LEGACY = 2'b10
    } scm_mode_t;

    typedef enum logic [1:0] {
        SCM_SRC_CFG = 2'b00,
        SCM_SRC_MEM = 2'b01,
        SCM_SRC_MGMT = 2'b10,
        SCM_SRC_SIDE = 2'b11
    } scm_src_t;

    typedef struct packed {
        logic valid;
        logic write;
        scm_src_t src;
        logic virt_side;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } scm_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [31:0] rdata;
    } scm_rsp_t;

    typedef struct packed {
        logic [4:0] port_num;
        logic upstream;
        logic acs_en;
        scm_mode_t mode;
    } scm_cfg_t;

endpackage : scm_pkg

/* File: hw/scm_rom.sv */
// Capability chain header lookup for one port.
`timescale 1ns/10ps
`default_nettype none
module scm_rom
(
    input wire logic [11:0] addr,
    input wire logic mcast_on,
    input wire logic acs_on,
    input wire logic pwrb_on,
    output logic hit,
    output logic [31:0] data
);
    import scm_pkg::*;

    // ****************************************************************
    // Header word builders.
    // ****************************************************************
    function automatic logic [31:0] std_hdr(input logic [11:0] nxt,
                                            input logic [7:0] id);
        std_hdr = {16'h0000, nxt[7:0], id};
    endfunction

    function automatic logic [31:0] ext_hdr(input logic [11:0] nxt,
                                            input logic [15:0] id);
        ext_hdr = {nxt, SCM_XVER, id};
    endfunction

    // Chain decode; absent blocks leave hit low so the word reads zero.
    always_comb
    begin
        hit = 1'b1;
        data = SCM_ZERO;
        case (addr)
            SCM_OFF_CAPPTR: data = {24'h000000, SCM_OFF_PM[7:0]};
            SCM_OFF_PM: data = std_hdr(SCM_OFF_MSI, SCM_ID_PM);
            SCM_OFF_MSI: data = std_hdr(SCM_OFF_EXP, SCM_ID_MSI);
            SCM_OFF_EXP: data = std_hdr(SCM_OFF_SSID, SCM_ID_EXP);
            SCM_OFF_SSID: data = std_hdr(SCM_OFF_NONE, SCM_ID_SSID);
            SCM_OFF_DSN: data = ext_hdr(SCM_OFF_AER, SCM_XID_DSN);
            SCM_OFF_AER: data = ext_hdr(SCM_OFF_PWRB, SCM_XID_AER);
            SCM_OFF_PWRB:
            begin
                hit = pwrb_on;
                data = pwrb_on ? ext_hdr(SCM_OFF_VC, SCM_XID_PWRB) : SCM_ZERO;
            end
            SCM_OFF_VC: data = ext_hdr(mcast_on ? SCM_OFF_MCAST : SCM_OFF_NONE,
                                       SCM_XID_VC);
            SCM_OFF_MCAST:
            begin
                hit = mcast_on;
                data = mcast_on ? ext_hdr(acs_on ? SCM_OFF_ACS : SCM_OFF_VEND,
                                          SCM_XID_MCAST) : SCM_ZERO;
            end
            SCM_OFF_ACS:
            begin
                hit = acs_on;
                data = acs_on ? ext_hdr(SCM_OFF_VEND, SCM_XID_ACS)
                              : SCM_ZERO;
            end
            SCM_OFF_VEND: data = ext_hdr(SCM_OFF_NONE, SCM_XID_VEND);
            default: hit = 1'b0;
        endcase
    end

endmodule // scm_rom
`default_nettype wire

/* File: sim/scm_port_map_asserts.sv */
// Checker of answer timing, header words and virtual switch group presence of the port map.
`timescale 1ns/10ps
`default_nettype none
module scm_port_map_asserts
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire scm_pkg::scm_cfg_t cfg,
    input wire scm_pkg::scm_req_t req,
    input wire scm_pkg::scm_rsp_t rsp,
    input wire logic stn_present,
    input wire logic chip_present,
    input wire logic vsw_present
);
    import scm_pkg::*;
    logic rd;
    // A read request is the cause of every header word check.
    assign rd = req.valid && !req.write;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_ans; req.valid |=> rsp.valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_pm; rd && req.addr == 12'h040 |=> rsp.rdata == 32'h0000_4801;
    endproperty
    a_pm: assert property (p_pm) else $error("bad pm word");
    property p_msi; rd && req.addr == 12'h048 |=> rsp.rdata == 32'h0000_6805;
    endproperty
    a_msi: assert property (p_msi) else $error("bad msi word");
    property p_exp; rd && req.addr == 12'h068 |=> rsp.rdata == 32'h0000_a410;
    endproperty
    a_exp: assert property (p_exp) else $error("bad express word");
    property p_dsn; rd && req.addr == 12'h100 |=> rsp.rdata == 32'hfb41_0003;
    endproperty
    a_dsn: assert property (p_dsn) else $error("bad serial word");
    property p_aer; rd && req.addr == 12'hfb4 |=> rsp.rdata == 32'h1381_0001;
    endproperty
    a_aer: assert property (p_aer) else $error("bad error word");
    property p_vc; rd && req.addr == 12'h148 |=> rsp.rdata ==
        (cfg.mode == SCM_MODE_LEGACY ? 32'h0001_0002 : 32'he001_0002);
    endproperty
    a_vc: assert property (p_vc) else $error("bad channel word");
    property p_vsw; vsw_present ==
        $past(cfg.port_num == 5'h00 && cfg.mode == SCM_MODE_VSW); endproperty
    a_vsw: assert property (p_vsw) else $error("bad vsw presence");
    property p_miss; req.valid && req.addr == 12'hfe0 |=>
        !rsp.hit && rsp.rdata == 32'h0000_0000; endproperty
    a_miss: assert property (p_miss) else $error("reserved hit");
    property p_wr; req.valid && req.write |=> rsp.rdata == 32'h0000_0000;
    endproperty
    a_wr: assert property (p_wr) else $error("write returned data");
    // Main scenarios reached by the bench.
    c_vc: cover property (rd && req.addr == 12'h148);
    c_mgmt: cover property (req.valid && req.src == SCM_SRC_MGMT);
    c_vsw: cover property (vsw_present);
endmodule // scm_port_map_asserts
bind scm_port_map scm_port_map_asserts scm_port_map_asserts_i (.sys_clk,
    .reset, .cfg, .req, .rsp, .stn_present, .chip_present, .vsw_present);
`default_nettype wire

/* File: sim/scm_host_model.sv */
// Host requester model issuing single-word register requests.
`timescale 1ns/10ps
`default_nettype none
module scm_host_model
(
    input wire logic sys_clk,
    input wire scm_pkg::scm_rsp_t rsp,
    output var scm_pkg::scm_req_t req
);
    import scm_pkg::*;
    // The request starts idle with valid low.
    initial req = '0;
    // One word per request, held for one edge; reply sampled a cycle later.
    task automatic access(input logic wr, input scm_src_t s, input logic v,
        input logic [11:0] a, input logic [31:0] d, output logic hit,
        output logic [31:0] q);
        @(negedge sys_clk);
        req = '{1'b1, wr, s, v, a, 4'hf, d};
        @(negedge sys_clk);
        hit = rsp.hit;
        q = rsp.rdata;
        // Released address and data lines show an inverted pattern, not the old value.
        req = '{1'b0, req.write, req.src, req.virt_side, ~req.addr, req.be,
                ~req.wdata};
    endtask
endmodule // scm_host_model
`default_nettype wire

/* File: sim/tb_switch_port_config_space_map.sv */
// Self-checking bench of the per-port configuration space map.
`timescale 1ns/10ps
`default_nettype none
module tb_switch_port_config_space_map;
    import scm_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    scm_cfg_t cfg = '{5'h00, 1'b1, 1'b1, SCM_MODE_BASE};
    scm_req_t req;
    scm_rsp_t rsp;
    logic stn_present, chip_present, vsw_present, hit;
    logic [31:0] q;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    scm_src_t s;
    scm_port_map scm_port_map_i (.sys_clk(sys_clk), .reset(reset),
        .cfg(cfg), .req(req), .rsp(rsp), .stn_present(stn_present),
        .chip_present(chip_present), .vsw_present(vsw_present));
    scm_host_model scm_host_model_i (.sys_clk(sys_clk), .rsp(rsp), .req(req));
    // Clock of 40 ns period.
    initial forever #20 sys_clk = ~sys_clk;
    // Cut a hang short after a cycle ceiling.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp1(input string w, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %0h got %0h", w, e, g);
        end
    endtask
    task automatic cmp32(input string w, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", w, e, g);
        end
    endtask
    // Read one word and compare hit and data.
    task automatic rc(input scm_src_t sr, input logic v, input logic [11:0] a,
        input logic eh, input logic [31:0] ed);
        scm_host_model_i.access(1'b0, sr, v, a, 32'h0000_0000, hit, q);
        cmp1($sformatf("hit %h", a), eh, hit);
        cmp32($sformatf("data %h", a), ed, q);
    endtask
    task automatic wr(input scm_src_t sr, input logic [11:0] a,
        input logic [31:0] d, input logic eh);
        scm_host_model_i.access(1'b1, sr, 1'b0, a, d, hit, q);
        cmp1($sformatf("write hit %h", a), eh, hit);
        cmp32("write reply", 32'h0000_0000, q);
    endtask
    // Change the port setup and check the group presence levels.
    task automatic setc(input logic [4:0] p, input logic u, input logic c,
        input scm_mode_t m, input logic es, input logic ec, input logic ev);
        @(negedge sys_clk);
        cfg = '{p, u, c, m};
        repeat (2) @(negedge sys_clk);
        cmp1("stn", es, stn_present);
        cmp1("chip", ec, chip_present);
        cmp1("vsw", ev, vsw_present);
    endtask
    // Main sequence of accesses.
    initial
    begin
        repeat (20) @(negedge sys_clk);
        reset = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            s = i ? SCM_SRC_MEM : SCM_SRC_CFG;
            rc(s, 1'b0, 12'h034, 1'b1, 32'h0000_0040);
            rc(s, 1'b0, 12'h040, 1'b1, 32'h0000_4801);
            rc(s, 1'b0, 12'h048, 1'b1, 32'h0000_6805);
            rc(s, 1'b0, 12'h068, 1'b1, 32'h0000_a410);
            rc(s, 1'b0, 12'h0a4, 1'b1, 32'h0000_000d);
            rc(s, 1'b0, 12'h100, 1'b1, 32'hfb41_0003);
            rc(s, 1'b0, 12'hfb4, 1'b1, 32'h1381_0001);
            rc(s, 1'b0, 12'h138, 1'b1, 32'h1481_0004);
            rc(s, 1'b0, 12'h148, 1'b1, 32'he001_0002);
            rc(s, 1'b0, 12'he00, 1'b1, 32'hf241_0012);
            rc(s, 1'b0, 12'hf24, 1'b1, 32'hb701_000d);
            rc(s, 1'b0, 12'hb70, 1'b1, 32'h0001_000b);
        end
        wr(SCM_SRC_CFG, 12'h040, 32'hffff_ffff, 1'b1);
        rc(SCM_SRC_CFG, 1'b0, 12'h040, 1'b1, 32'h0000_4801);
        wr(SCM_SRC_CFG, 12'hfe0, 32'hffff_ffff, 1'b0);
        rc(SCM_SRC_CFG, 1'b0, 12'hfe0, 1'b0, 32'h0000_0000);
        setc(5'h00, 1'b1, 1'b1, SCM_MODE_BASE, 1'b1, 1'b1, 1'b0);
        wr(SCM_SRC_MEM, 12'h200, 32'h1234_5678, 1'b1);
        wr(SCM_SRC_CFG, 12'h260, 32'h0000_abcd, 1'b1);
        rc(SCM_SRC_MEM, 1'b0, 12'h200, 1'b1, 32'h1234_5678);
        rc(SCM_SRC_CFG, 1'b0, 12'h260, 1'b1, 32'h0000_abcd);
        rc(SCM_SRC_MGMT, 1'b0, 12'h900, 1'b0, 32'h0000_0000);
        setc(5'h00, 1'b0, 1'b0, SCM_MODE_BASE, 1'b1, 1'b1, 1'b0);
        rc(SCM_SRC_CFG, 1'b0, 12'h138, 1'b0, 32'h0000_0000);
        rc(SCM_SRC_CFG, 1'b0, 12'he00, 1'b1, 32'hb701_0012);
        rc(SCM_SRC_CFG, 1'b0, 12'hf24, 1'b0, 32'h0000_0000);
        setc(5'h05, 1'b1, 1'b1, SCM_MODE_BASE, 1'b0, 1'b0, 1'b0);
        rc(SCM_SRC_CFG, 1'b0, 12'h200, 1'b0, 32'h0000_0000);
        wr(SCM_SRC_CFG, 12'h200, 32'hdead_beef, 1'b0);
        setc(5'h10, 1'b1, 1'b1, SCM_MODE_BASE, 1'b1, 1'b0, 1'b0);
        rc(SCM_SRC_CFG, 1'b0, 12'h200, 1'b1, 32'h1234_5678);
        rc(SCM_SRC_CFG, 1'b0, 12'h260, 1'b0, 32'h0000_0000);
        setc(5'h14, 1'b1, 1'b1, SCM_MODE_VSW, 1'b1, 1'b0, 1'b0);
        rc(SCM_SRC_MGMT, 1'b0, 12'h900, 1'b0, 32'h0000_0000);
        rc(SCM_SRC_CFG, 1'b0, 12'h200, 1'b0, 32'h0000_0000);
        setc(5'h00, 1'b1, 1'b1, SCM_MODE_VSW, 1'b1, 1'b1, 1'b1);
        rc(SCM_SRC_CFG, 1'b0, 12'h260, 1'b0, 32'h0000_0000);
        rc(SCM_SRC_MGMT, 1'b0, 12'h260, 1'b1, 32'h0000_abcd);
        rc(SCM_SRC_SIDE, 1'b0, 12'h200, 1'b1, 32'h1234_5678);
        rc(SCM_SRC_MGMT, 1'b0, 12'h900, 1'b1, 32'h1234_5678);
        setc(5'h00, 1'b1, 1'b1, SCM_MODE_LEGACY, 1'b1, 1'b1, 1'b0);
        rc(SCM_SRC_CFG, 1'b0, 12'h148, 1'b1, 32'h0001_0002);
        rc(SCM_SRC_CFG, 1'b0, 12'he00, 1'b0, 32'h0000_0000);
        rc(SCM_SRC_CFG, 1'b0, 12'h200, 1'b0, 32'h0000_0000);
        rc(SCM_SRC_CFG, 1'b1, 12'h260, 1'b1, 32'h0000_abcd);
        close_out();
    end
endmodule // tb_switch_port_config_space_map
`default_nettype wire
